// *** include/fpec_consts.vh ***
// constants for the flash program and erase control block
`ifndef FPEC_CONSTS_VH
`define FPEC_CONSTS_VH
// register byte offsets
`define FPEC_OFS_CTRL   12'h000
`define FPEC_OFS_KEY    12'h004
`define FPEC_OFS_ADDR   12'h008
// program_control field positions
`define FPEC_BIT_TRIG   15
`define FPEC_BIT_ARM    14
`define FPEC_BIT_FAIL   13
`define FPEC_BIT_UVERR  12
`define FPEC_BIT_UVLIVE 11
`define FPEC_OP_HI      3
`define FPEC_OP_LO      0
// operation codes
`define FPEC_OP_CLEAR   4'h0
`define FPEC_OP_WORD    4'h1
`define FPEC_OP_ROW     4'h3
`define FPEC_OP_PAGE    4'h4
`define FPEC_OP_ARRAY   4'h5
// address alignment: 1 KB page, 128 byte row, 32-bit word
`define FPEC_PAGE_LSB   10
`define FPEC_ROW_LSB    7
`define FPEC_WORD_LSB   2
// reset values
`define FPEC_RST_ADDR   32'h0000_0000
`define FPEC_RST_OP     4'h0
`define FPEC_ZERO32     32'h0000_0000
// unlock key pair, values arbitrary
`define FPEC_KEY_FIRST  32'hC3C3_0F0F
`define FPEC_KEY_SECOND 32'h3C3C_F0F0
`endif

// *** design/fpec_seq.v ***
// operation sequencer: protection check and flash handshake
`include "fpec_consts.vh"
`default_nettype none
module fpec_seq (
  input  wire        ref_clk_in,
  input  wire        por_resetn_in,
  input  wire        start_in,
  input  wire [3:0]  op_in,
  input  wire [31:0] addr_in,
  input  wire        abort_in,
  input  wire        array_protected_in,
  input  wire        target_protected_in,
  input  wire        flash_done_in,
  input  wire        flash_fail_in,
  output reg         flash_req_out,
  output reg         flash_abort_out,
  output reg  [3:0]  flash_cmd_out,
  output reg  [31:0] flash_addr_out,
  output reg         done_out,
  output reg         fail_out
);
  localparam S_IDLE  = 2'h0;
  localparam S_CHECK = 2'h1;
  localparam S_WAIT  = 2'h2;

  reg [1:0]  state;
  reg        real_op;
  reg        prot;
  reg [31:0] aligned;

  ////////////////////////////////////////////////////////////////
  // decode the code and align the target to its unit
  always @* begin
    real_op = 1'b1;
    aligned = addr_in;
    case (op_in)
      `FPEC_OP_WORD: aligned = {addr_in[31:`FPEC_WORD_LSB], {`FPEC_WORD_LSB{1'b0}}};
      `FPEC_OP_ROW: aligned = {addr_in[31:`FPEC_ROW_LSB], {`FPEC_ROW_LSB{1'b0}}};
      `FPEC_OP_PAGE: aligned = {addr_in[31:`FPEC_PAGE_LSB], {`FPEC_PAGE_LSB{1'b0}}};
      `FPEC_OP_ARRAY: aligned = `FPEC_ZERO32; // address disregarded
      default: real_op = 1'b0; // no-op and reserved codes
    endcase
  end

  // whole array needs every page free, others only the target
  always @* begin
    prot = (flash_cmd_out == `FPEC_OP_ARRAY) ? array_protected_in
                                              : target_protected_in;
  end

  ////////////////////////////////////////////////////////////////
  // state machine; protection is sampled on the latched address
  always @(posedge ref_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      state           <= S_IDLE;
      flash_req_out   <= 1'b0;
      flash_abort_out <= 1'b0;
      flash_cmd_out   <= `FPEC_RST_OP;
      flash_addr_out  <= `FPEC_RST_ADDR;
      done_out        <= 1'b0;
      fail_out        <= 1'b0;
    end else begin
      done_out        <= 1'b0;
      flash_req_out   <= 1'b0;
      flash_abort_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_in) begin
            flash_cmd_out  <= op_in;
            flash_addr_out <= aligned;
            if (real_op) begin
              state <= S_CHECK;
            end else begin
              done_out <= 1'b1; // finishes next cycle
              fail_out <= 1'b0;
            end
          end
        end
        S_CHECK: begin
          if (prot | abort_in) begin
            done_out <= 1'b1; // nothing touched
            fail_out <= 1'b1;
            state    <= S_IDLE;
          end else begin
            flash_req_out <= 1'b1;
            state         <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (abort_in) begin
            flash_abort_out <= 1'b1;
            done_out        <= 1'b1;
            fail_out        <= 1'b1;
            state           <= S_IDLE;
          end else if (flash_done_in) begin
            done_out <= 1'b1;
            fail_out <= flash_fail_in;
            state    <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/fpec_top.v ***
// flash program and erase control: APB registers, unlock and flags
`include "fpec_consts.vh"
`default_nettype none
module fpec_top #(
  parameter ADDR_W = 12
) (
  input  wire              ref_clk_in,
  input  wire              resetn_in,
  input  wire              por_resetn_in,
  // apb slave
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  output reg  [31:0]       prdata_out,
  output wire              pready_out,
  output wire              pslverr_out,
  // supply monitor
  input  wire              undervolt_sense_in,
  output wire              undervolt_monitor_en_out,
  // protection status from the array
  input  wire              array_protected_in,
  input  wire              target_protected_in,
  // flash array handshake
  input  wire              flash_done_in,
  input  wire              flash_fail_in,
  output wire              flash_req_out,
  output wire              flash_abort_out,
  output wire [3:0]        flash_cmd_out,
  output wire [31:0]       flash_addr_out,
  output wire              busy_out
);
  localparam U_IDLE = 2'h0;
  localparam U_HALF = 2'h1;
  localparam U_OPEN = 2'h2;

  // control and status state
  reg         write_arm;
  reg         trigger;
  reg         op_fail_flag;
  reg         undervolt_error_flag;
  reg         undervolt_live_flag;
  reg  [3:0]  operation_select;
  reg  [31:0] target_location;
  reg  [1:0]  unlock_state;
  reg  [1:0]  next_unlock_state;
  reg         bad_addr;
  reg  [31:0] next_rdata;
  reg         next_bad;

  wire        setup;
  wire        access;
  wire        wr;
  wire        hit_ctrl;
  wire        hit_key;
  wire        hit_addr;
  wire        wr_ctrl;
  wire        wr_key;
  wire        wr_addr;
  wire        unlocked;
  wire        start;
  wire        clear_flags;
  wire        seq_done;
  wire        seq_fail;
  wire        uv_level;
  wire [31:0] ctrl_view;

  ////////////////////////////////////////////////////////////////
  // apb decode; zero wait states so every access ends at once
  assign setup    = psel_in & ~penable_in;
  assign access   = psel_in & penable_in;
  assign wr       = access & pwrite_in;
  assign hit_ctrl = (paddr_in == `FPEC_OFS_CTRL);
  assign hit_key  = (paddr_in == `FPEC_OFS_KEY);
  assign hit_addr = (paddr_in == `FPEC_OFS_ADDR);
  assign wr_ctrl  = wr & hit_ctrl;
  assign wr_key   = wr & hit_key;
  assign wr_addr  = wr & hit_addr;

  assign pready_out  = 1'b1;
  assign pslverr_out = access & bad_addr; // unmapped offset

  ////////////////////////////////////////////////////////////////
  // unlock tracker: any access other than the expected one
  // drops the lock, so a stray store cannot start an erase
  always @* begin
    next_unlock_state = unlock_state;
    if (access) begin
      if (wr_key && pwdata_in == `FPEC_KEY_FIRST) begin
        next_unlock_state = U_HALF;
      end else if (unlock_state == U_HALF && wr_key &&
                   pwdata_in == `FPEC_KEY_SECOND) begin
        next_unlock_state = U_OPEN;
      end else begin
        next_unlock_state = U_IDLE; // deviation or used up
      end
    end
  end

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unlock_state <= U_IDLE;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // open only for the single access right after the second key
  assign unlocked = (unlock_state == U_OPEN);

  ////////////////////////////////////////////////////////////////
  // start condition uses the stored arm bit, not the written one
  assign start = wr_ctrl & pwdata_in[`FPEC_BIT_TRIG] & write_arm &
                 unlocked & ~trigger;
  assign clear_flags = start & (operation_select == `FPEC_OP_CLEAR);

  ////////////////////////////////////////////////////////////////
  // write_arm is the only program_control bit that device reset touches
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      write_arm <= 1'b0;
    end else if (wr_ctrl) begin
      write_arm <= pwdata_in[`FPEC_BIT_ARM];
    end
  end

  // monitor runs only while armed
  assign undervolt_monitor_en_out = write_arm;
  assign uv_level = write_arm & undervolt_sense_in;

  ////////////////////////////////////////////////////////////////
  // trigger: set by an accepted start, cleared by the sequencer
  always @(posedge ref_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      trigger <= 1'b0;
    end else if (start) begin
      trigger <= 1'b1;
    end else if (seq_done) begin
      trigger <= 1'b0; // hardware clear on finish
    end
  end

  assign busy_out = trigger;

  ////////////////////////////////////////////////////////////////
  // operation select: frozen while armed or busy; kept over
  // device reset so a resumed flow sees the same code
  always @(posedge ref_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      operation_select <= `FPEC_RST_OP;
    end else if (wr_ctrl && !write_arm && !trigger) begin
      operation_select <= pwdata_in[`FPEC_OP_HI:`FPEC_OP_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // target address, ignored while an operation runs
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      target_location <= `FPEC_RST_ADDR;
    end else if (wr_addr && !trigger) begin
      target_location <= pwdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////
  // status flags: a hardware set in the clearing cycle wins
  always @(posedge ref_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      op_fail_flag         <= 1'b0;
      undervolt_error_flag <= 1'b0;
      undervolt_live_flag  <= 1'b0;
    end else begin
      if (seq_done) begin
        op_fail_flag <= seq_fail; // clean finish reads zero
      end else if (clear_flags) begin
        op_fail_flag <= 1'b0;
      end
      if (uv_level) begin
        undervolt_error_flag <= 1'b1;
      end else if (clear_flags) begin
        undervolt_error_flag <= 1'b0;
      end
      // live flag is a level, so resampling also covers the clear
      undervolt_live_flag <= uv_level;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read view of program_control; holes read zero
  assign ctrl_view = {16'h0000,
                      trigger,
                      write_arm,
                      op_fail_flag,
                      undervolt_error_flag,
                      undervolt_live_flag,
                      7'h00,
                      operation_select};

  // read data is prepared in setup and held through access
  always @* begin
    next_rdata = `FPEC_ZERO32;
    next_bad   = 1'b0;
    if (hit_ctrl) begin
      next_rdata = ctrl_view;
    end else if (hit_key) begin
      next_rdata = `FPEC_ZERO32; // write-only port
    end else if (hit_addr) begin
      next_rdata = target_location;
    end else begin
      next_bad = 1'b1;
    end
  end

  always @(posedge ref_clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      prdata_out <= `FPEC_ZERO32;
      bad_addr   <= 1'b0;
    end else if (setup) begin
      prdata_out <= pwrite_in ? `FPEC_ZERO32 : next_rdata;
      bad_addr   <= next_bad;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencer; an undervolt event during a run aborts it
  fpec_seq u_seq (
    .ref_clk_in          (ref_clk_in),
    .por_resetn_in       (por_resetn_in),
    .start_in            (start),
    .op_in               (operation_select),
    .addr_in             (target_location),
    .abort_in            (trigger & undervolt_live_flag),
    .array_protected_in  (array_protected_in),
    .target_protected_in (target_protected_in),
    .flash_done_in       (flash_done_in),
    .flash_fail_in       (flash_fail_in),
    .flash_req_out       (flash_req_out),
    .flash_abort_out     (flash_abort_out),
    .flash_cmd_out       (flash_cmd_out),
    .flash_addr_out      (flash_addr_out),
    .done_out            (seq_done),
    .fail_out            (seq_fail)
  );
endmodule
`default_nettype wire

// *** verification/fpec_monitor.sv ***
// assertion checker for the flash program and erase control block
`include "fpec_consts.vh"
`default_nettype none
module fpec_monitor #(
  parameter ADDR_W = 12
) (
  input wire logic              ref_clk_in,
  input wire logic              resetn_in,
  input wire logic              por_resetn_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              undervolt_monitor_en_out,
  input wire logic              flash_done_in,
  input wire logic              flash_req_out,
  input wire logic [3:0]        flash_cmd_out,
  input wire logic [31:0]       flash_addr_out,
  input wire logic              busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_clk @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in || !por_resetn_in);
  // access phase decode, pready is always high here
  wire rd_acc = psel_in && penable_in && !pwrite_in;
  wire wr_acc = psel_in && penable_in && pwrite_in;
  ////////////////////////////////////////////////////////////////////////////
  // trigger rising, then either a flash request or a quick clear
  sequence s_launch;
    !busy_out ##1 busy_out;
  endsequence
  sequence s_finish;
    busy_out && flash_done_in;
  endsequence
  AST_KEY_READ: assert property (
    rd_acc && paddr_in == `FPEC_OFS_KEY |-> prdata_out == 32'h0000_0000)
    else $error("key port read back nonzero");
  AST_CTRL_RSV: assert property (
    rd_acc && paddr_in == `FPEC_OFS_CTRL |-> (prdata_out & 32'hFFFF_07F0) == 32'h0000_0000)
    else $error("unimplemented control bits read nonzero");
  AST_NO_ARM: assert property (
    !undervolt_monitor_en_out && !busy_out |=> !busy_out)
    else $error("trigger set while disarmed");
  AST_MON_EN: assert property (
    wr_acc && paddr_in == `FPEC_OFS_CTRL |=> undervolt_monitor_en_out == $past(pwdata_in[14]))
    else $error("monitor enable does not follow arm bit");
  AST_REQ_BUSY: assert property (
    flash_req_out |-> busy_out)
    else $error("flash request without trigger");
  AST_REQ_CMD: assert property (
    flash_req_out |-> flash_cmd_out inside {4'h1, 4'h3, 4'h4, 4'h5})
    else $error("flash request for a no-op code");
  AST_ALIGN: assert property (
    flash_req_out |-> (flash_cmd_out == 4'h5 ? flash_addr_out == 32'h0000_0000 :
      flash_cmd_out == 4'h4 ? flash_addr_out[9:0] == 10'h000 :
      flash_cmd_out == 4'h3 ? flash_addr_out[6:0] == 7'h00 : flash_addr_out[1:0] == 2'h0))
    else $error("flash address not aligned to unit");
  AST_START: assert property (
    s_launch |-> ##[0:4] (flash_req_out || !busy_out))
    else $error("started operation neither requested nor cleared");
  AST_DONE: assert property (
    s_finish |-> ##[1:3] !busy_out)
    else $error("trigger not cleared after completion");
endmodule
bind fpec_top fpec_monitor #(.ADDR_W(ADDR_W)) u_fpec_monitor (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .por_resetn_in(por_resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .undervolt_monitor_en_out(undervolt_monitor_en_out), .flash_done_in(flash_done_in),
  .flash_req_out(flash_req_out), .flash_cmd_out(flash_cmd_out),
  .flash_addr_out(flash_addr_out), .busy_out(busy_out));
`default_nettype wire

// *** verification/fpec_bench.sv ***
// self-checking bench for the flash program and erase control block
`include "fpec_consts.vh"
`default_nettype none
module fpec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, porn, psel, penable, pwrite, pready, perr, uvs, mon;
  logic        aprot, tprot, done, ffail, req, abrt, busy, pslv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, faddr, raddr;
  logic [3:0]  cmd, rcmd;
  logic [7:0]  dly = 8'h00;
  logic [3:0]  nop [5] = '{4'h0, 4'h2, 4'h6, 4'h7, 4'hF};
  int          fail_count = 0, checked = 0, reqs = 0, aborts = 0;
  fpec_top u_fpec_top (
    .ref_clk_in(clk), .resetn_in(rstn), .por_resetn_in(porn), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslv),
    .undervolt_sense_in(uvs), .undervolt_monitor_en_out(mon),
    .array_protected_in(aprot), .target_protected_in(tprot), .flash_done_in(done),
    .flash_fail_in(ffail), .flash_req_out(req), .flash_abort_out(abrt),
    .flash_cmd_out(cmd), .flash_addr_out(faddr), .busy_out(busy));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  // array stand-in: finishes nine cycles after each request, so busy lasts
  always @(posedge clk) begin
    if (abrt === 1'b1) begin
      aborts <= aborts + 1; // undervolt abort pulses seen
    end
    if (req === 1'b1) begin
      dly <= 8'h08;
      rcmd <= cmd;
      raddr <= faddr;
      reqs <= reqs + 1;
    end else if (dly != 8'h00) begin
      dly <= dly - 8'h01;
    end
    done <= (dly == 8'h01);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      complete_run();
    end
    rdat = prdata;
    perr = pslv;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // select, arm, unlock and trigger; select written twice to drop arm first
  task automatic go(input logic [3:0] op, input logic [31:0] a);
    acc(1'b1, `FPEC_OFS_CTRL, {28'h0000000, op});
    acc(1'b1, `FPEC_OFS_CTRL, {28'h0000000, op});
    acc(1'b1, `FPEC_OFS_ADDR, a);
    acc(1'b1, `FPEC_OFS_CTRL, {28'h0000400, op});
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1'b1, `FPEC_OFS_CTRL, {28'h0000C00, op});
  endtask
  task automatic fin();
    int n;
    for (n = 0; n < 100; n++) begin
      if (busy === 1'b0) break;
      @(posedge clk);
    end
    if (n == 100) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic run(input logic [3:0] op, input logic [31:0] a, input logic fl,
                     input logic rq, input logic [31:0] ea);
    int r0;
    r0 = reqs;
    go(op, a);
    fin();
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, {18'h00001, fl, 9'h000, op});
    chk(reqs - r0, {31'h0, rq});
    if (rq) begin
      chk(rcmd, op);
      chk(raddr, ea);
    end
  endtask
  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, uvs, aprot, tprot, ffail} = 7'h00;
    {paddr, pwdata} = 44'h000_0000_0000;
    rstn = 1'b0;
    porn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    porn <= 1'b1;
    @(posedge clk);
    // reset values, write-only key, full-width target, unmapped offset
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1'b0, `FPEC_OFS_KEY, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    acc(1'b0, `FPEC_OFS_ADDR, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    acc(1'b1, `FPEC_OFS_ADDR, 32'hFFFF_FFFF);
    acc(1'b0, `FPEC_OFS_ADDR, 32'h0000_0000);
    chk(rdat, 32'hFFFF_FFFF);
    acc(1'b0, 12'h00C, 32'h0000_0000);
    chk(perr, 1'b1);
    acc(1'b1, `FPEC_OFS_CTRL, 32'hFFFF_BFF0);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    $display("test registers done");
    // locked trigger attempts: no key, keys reversed, access between second key and trigger
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_4001);
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_4003);
    chk(mon, 1'b1);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_4001);
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_C001);
    chk(busy, 1'b0);
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_C001);
    chk(busy, 1'b0);
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1'b1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_C001);
    chk(busy, 1'b0);
    $display("test lock done");
    // every operation, unaligned target, then no-op codes 0, 2, 6, 7 and F
    run(4'h1, 32'h0000_1FFF, 1'b0, 1'b1, 32'h0000_1FFC);
    run(4'h3, 32'h0000_1FFF, 1'b0, 1'b1, 32'h0000_1F80);
    run(4'h4, 32'h0000_1FFF, 1'b0, 1'b1, 32'h0000_1C00);
    run(4'h5, 32'h0000_1FFF, 1'b0, 1'b1, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      run(nop[i], 32'h0000_0100, 1'b0, 1'b0, 32'h0000_0000);
    end
    // target address writes while busy are dropped
    go(4'h4, 32'h0000_0400);
    acc(1'b1, `FPEC_OFS_ADDR, 32'h0000_0800);
    acc(1'b0, `FPEC_OFS_ADDR, 32'h0000_0000);
    chk(rdat, 32'h0000_0400);
    fin();
    $display("test operations done");
    // protection refusals, flag clear, undervolt and device reset
    tprot <= 1'b1;
    run(4'h4, 32'h0000_0800, 1'b1, 1'b0, 32'h0000_0000);
    tprot <= 1'b0;
    run(4'h0, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
    aprot <= 1'b1;
    run(4'h5, 32'h0000_0000, 1'b1, 1'b0, 32'h0000_0000);
    aprot <= 1'b0;
    uvs <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_7805);
    uvs <= 1'b0;
    repeat (3) @(posedge clk);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_7005);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_3005);
    run(4'h0, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
    acc(1'b1, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(mon, 1'b0);
    uvs <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    uvs <= 1'b0;
    // undervolt during a run aborts it and marks it failed
    go(4'h1, 32'h0000_0100);
    uvs <= 1'b1;
    fin();
    acc(1'b0, `FPEC_OFS_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_7801);
    chk(aborts, 32'h0000_0001);
    uvs <= 1'b0;
    $display("test flags done");
    complete_run();
  end
endmodule
`default_nettype wire
